// file: bench/pfb_power_stage.sv
`timescale 1ns/1ps
module pfb_power_stage (
  input wire logic i_fault_cmd,
  input wire logic i_limit_cmd,
  output logic o_safety_fault_n,
  output logic o_current_limit
);
  // pull-up keeps the pin inactive high unless a fault is commanded
  assign o_safety_fault_n = !i_fault_cmd;
  assign o_current_limit = i_limit_cmd;
endmodule

// file: bench/pfb_top_assertions.sv
`timescale 1ns/1ps
module pfb_top_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic i_re,
  input wire logic i_pwm_high,
  input wire logic i_pwm_low,
  input wire logic i_safety_fault_n,
  input wire logic i_current_limit,
  input wire logic [15:0] o_rdata,
  input wire logic o_pwm_high,
  input wire logic o_pwm_low,
  input wire logic o_fault_active,
  input wire logic o_safety_pin_owned
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ownership is promised while reset is held, whatever the mode was
  property p_own;
    disable iff (1'b0) !i_nrst ##1 !i_nrst |-> o_safety_pin_owned;
  endproperty
  a_own: assert property (p_own) else $error("pin not owned");
  property p_trip; i_ce && !i_safety_fault_n |=> o_fault_active; endproperty
  a_trip: assert property (p_trip) else $error("no trip");
  property p_safe; o_fault_active |-> !o_pwm_high && !o_pwm_low; endproperty
  a_safe: assert property (p_safe) else $error("not safe");
  property p_pass;
    i_ce |=> o_fault_active || o_pwm_high == $past(i_pwm_high)
      && o_pwm_low == $past(i_pwm_low);
  endproperty
  a_pass: assert property (p_pass) else $error("bad pass");
  property p_idle; !$past(i_re) |-> o_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_gap;
    $past(i_re) && $past(i_addr) == 4'h0 |-> o_rdata[9:6] == 4'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("unused bits set");
  property p_unmap;
    $past(i_re) && $past(i_addr) > 4'h4 |-> o_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_stat;
    $past(i_re) && $past(i_addr) == 4'h4 |->
      o_rdata[5:4] == {$past(o_safety_pin_owned), $past(i_safety_fault_n)};
  endproperty
  a_stat: assert property (p_stat) else $error("bad status");
  c_trip: cover property ($rose(o_fault_active));
  c_blank: cover property (i_current_limit && !o_fault_active);
  c_stat: cover property (i_re && i_addr == 4'h4);
  c_own: cover property (!o_safety_pin_owned);
endmodule
bind pfb_top pfb_top_checker i_chk (.*);

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import pfb_pkg::*;
  logic i_clk, i_nrst, i_ce, i_we, i_re, i_pwm_high, i_pwm_low;
  logic i_safety_fault_n, i_remap_fault_one, i_remap_fault_two;
  logic i_current_limit, fcmd, lcmd;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, d, i_blank_ext;
  logic o_pwm_high, o_pwm_low, o_fault_active, o_safety_pin_owned;
  int errors, n_checks, cycles;
  pfb_top #(.CW(16), .NEXT(16)) i_dut (.*);
  pfb_power_stage i_ps (
    .i_fault_cmd(fcmd),
    .i_limit_cmd(lcmd),
    .o_safety_fault_n(i_safety_fault_n),
    .o_current_limit(i_current_limit)
  );
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  task complete_run;
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_we <= 1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_we <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge i_clk);
    i_re <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task t_regs;
    rd(4'h0);
    chk(d, 16'h0000);
    rd(4'h1);
    chk(d, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0);
    chk(d, 16'hfc3f);
    wr(4'hf, 16'hffff);
    rd(4'hf);
    chk(d, 16'h0000);
    wr(4'h0, 16'h0000);
  endtask
  task t_latch;
    @(posedge i_clk);
    i_pwm_high <= 1;
    fcmd <= 1;
    @(posedge i_clk);
    @(negedge i_clk);
    chk(o_fault_active, 1);
    chk(o_pwm_high, 0);
    // clear while the pin is still low must be refused
    wr(4'h4, 16'h0001);
    @(posedge i_clk);
    fcmd <= 0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk(o_fault_active, 1);
    wr(4'h4, 16'h0001);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk(o_pwm_high, 1);
  endtask
  task t_mode;
    @(posedge i_clk);
    fcmd <= 1;
    wr(4'h1, 16'h0001);
    rd(4'h1);
    chk(d, 16'h0001);
    @(posedge i_clk);
    fcmd <= 0;
    wr(4'h4, 16'h0001);
    wr(4'h1, 16'h0010);
  endtask
  task t_win;
    int k, j;
    logic [15:0] leb;
    wr(4'h3, 16'h0004);
    for (k = 0; k < 4; k++) begin
      for (j = 0; j < 3; j++) begin
        // j=1 arms the opposite edge, j=2 drops the limit enable
        leb = (j == 2 ? 16'h0000 : 16'h0400) | (16'h8000 >> (k ^ (j == 1)));
        @(posedge i_clk);
        i_pwm_high <= (k == 1);
        i_pwm_low <= (k == 3);
        wr(4'h0, leb);
        // let any window from the setup edge run out
        repeat (6) @(posedge i_clk);
        i_pwm_high <= (k == 1) ^ (k < 2);
        i_pwm_low <= (k == 3) ^ (k > 1);
        @(posedge i_clk);
        lcmd <= 1;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_fault_active, j != 0);
        // last blanked edge of the window, then it has run out
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk(o_fault_active, j != 0);
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_fault_active, 1);
        @(posedge i_clk);
        lcmd <= 0;
      end
    end
  endtask
  task t_state;
    int i, j;
    logic v;
    wr(4'h2, 16'h0003);
    for (i = 0; i < 6; i++) begin
      for (j = 0; j < 2; j++) begin
        v = i[0] ^ j[0];
        wr(4'h0, 16'h0001 << i);
        @(posedge i_clk);
        i_pwm_low <= (i < 2) & v;
        i_pwm_high <= (i / 2 == 1) & v;
        i_blank_ext[3] <= (i > 3) & v;
        @(posedge i_clk);
        lcmd <= 1;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_fault_active, j);
        @(posedge i_clk);
        lcmd <= 0;
      end
    end
  endtask
  task t_src;
    wr(4'h0, 16'h0000);
    // cycle-by-cycle mode on the first remappable fault
    wr(4'h1, 16'h0005);
    @(posedge i_clk);
    i_remap_fault_one <= 1;
    @(posedge i_clk);
    @(negedge i_clk);
    chk(o_fault_active, 1);
    @(posedge i_clk);
    i_remap_fault_one <= 0;
    @(posedge i_clk);
    @(negedge i_clk);
    chk(o_fault_active, 0);
    // disabled mode on the second one; pin is handed back
    wr(4'h1, 16'h000b);
    @(posedge i_clk);
    i_remap_fault_two <= 1;
    rd(4'h4);
    chk(d, 16'h0010);
    chk(o_fault_active, 0);
  endtask
  task t_reset;
    // reset taken while the pin is not owned
    @(posedge i_clk);
    i_nrst <= 0;
    i_remap_fault_two <= 0;
    @(posedge i_clk);
    @(negedge i_clk);
    chk(o_safety_pin_owned, 1);
    chk(o_fault_active, 0);
    @(posedge i_clk);
    i_nrst <= 1;
    @(posedge i_clk);
    fcmd <= 1;
    @(posedge i_clk);
    @(negedge i_clk);
    chk(o_fault_active, 1);
    rd(4'h4);
    chk(d, 16'h0023);
    rd(4'h1);
    chk(d, 16'h0000);
  endtask
  initial begin
    i_nrst = 0;
    i_ce = 1;
    i_we = 0;
    i_re = 0;
    i_addr = 0;
    i_wdata = 0;
    i_pwm_high = 0;
    i_pwm_low = 0;
    i_remap_fault_one = 0;
    i_remap_fault_two = 0;
    i_blank_ext = 0;
    fcmd = 0;
    lcmd = 0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1;
    t_regs();
    t_latch();
    t_mode();
    t_win();
    t_state();
    t_src();
    t_reset();
    complete_run();
  end
endmodule

// file: rtl/pfb_blank_timer.sv
`timescale 1ns/1ps
`include "pfb_map.svh"

module pfb_blank_timer #(
  parameter int CW = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [CW-1:0] i_len,
  output logic o_active
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // a new edge restarts the window rather than extending a stale one
  always_comb begin
    cnt_d = cnt_q;
    if (i_start) begin
      cnt_d = i_len;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign o_active = (cnt_q != '0);
endmodule

// file: rtl/pfb_top.sv
`timescale 1ns/1ps
`include "pfb_map.svh"

// Function
// - safety fault pin stays owned by this block throughout reset.
// - after reset the safety fault is selected in latched mode.
// - an enabled, unblanked fault forces both outputs to the safe levels.
// - fault mode field is writable whatever the safety pin level.
// - bit 11 blanks the fault input, bit 10 the current-limit input.
// - bits 5/4 blank while selected external signal is high/low.
module pfb_top #(
  parameter int CW = 16,
  parameter int NEXT = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [15:0] o_rdata,
  input wire logic i_pwm_high,
  input wire logic i_pwm_low,
  input wire logic i_safety_fault_n,
  input wire logic i_remap_fault_one,
  input wire logic i_remap_fault_two,
  input wire logic i_current_limit,
  input wire logic [NEXT-1:0] i_blank_ext,
  output logic o_pwm_high,
  output logic o_pwm_low,
  output logic o_fault_active,
  output logic o_safety_pin_owned
);
  import pfb_pkg::*;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  logic [15:0] leb_q, leb_d;
  logic [15:0] fcl_q, fcl_d;
  logic [15:0] aux_q, aux_d;
  logic [CW-1:0] blk_q, blk_d;
  logic [15:0] rdata_q, rdata_d;
  pfb_state_t st_q, st_d;
  logic ph_q, ph_d, pl_q, pl_d;
  logic oh_q, oh_d, ol_q, ol_d;
  logic flt_q, flt_d;
  logic own_q, own_d;

  pfb_mode_t mode;
  pfb_src_t src;
  logic raw_fault, ext_sel, start, win, state_blk;
  logic fault_in, limit_in, fault_now, clear_req;
  logic [15:0] stat;

  assign mode = pfb_mode_t'(fcl_q[`PFB_FCL_MODE_LSB +: 2]);
  assign src = pfb_src_t'(fcl_q[`PFB_FCL_SRC_LSB +: 2]);

  always_comb begin
    case (src)
      PFB_SRC_SAFETY: raw_fault = ~i_safety_fault_n;
      PFB_SRC_REMAP1: raw_fault = i_remap_fault_one;
      PFB_SRC_REMAP2: raw_fault = i_remap_fault_two;
      default: raw_fault = 1'b0;
    endcase
  end

  // out-of-range select reads as a quiet low signal
  assign ext_sel = (aux_q[`PFB_AUX_SEL_LSB +: 4] < NEXT[4:0]) ?
                   i_blank_ext[aux_q[`PFB_AUX_SEL_LSB +: 4]] : 1'b0;

  assign start = (leb_q[`PFB_LEB_HRISE] & i_pwm_high & ~ph_q) |
                 (leb_q[`PFB_LEB_HFALL] & ~i_pwm_high & ph_q) |
                 (leb_q[`PFB_LEB_LRISE] & i_pwm_low & ~pl_q) |
                 (leb_q[`PFB_LEB_LFALL] & ~i_pwm_low & pl_q);

  pfb_blank_timer #(
    .CW(CW)
  ) u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_start(start),
    .i_len(blk_q),
    .o_active(win)
  );

  assign state_blk = (leb_q[`PFB_LEB_EXTH] & ext_sel) |
                     (leb_q[`PFB_LEB_EXTL] & ~ext_sel) |
                     (leb_q[`PFB_LEB_HH] & i_pwm_high) |
                     (leb_q[`PFB_LEB_HL] & ~i_pwm_high) |
                     (leb_q[`PFB_LEB_LH] & i_pwm_low) |
                     (leb_q[`PFB_LEB_LL] & ~i_pwm_low);

  // window blanking only where enabled, else unblanked
  assign fault_in = raw_fault & ~state_blk &
                    ~(win & leb_q[`PFB_LEB_FLTEN]);
  assign limit_in = i_current_limit & fcl_q[`PFB_FCL_LIMEN] & ~state_blk &
                    ~(win & leb_q[`PFB_LEB_LIMEN]);
  assign fault_now = fault_in & (mode != PFB_MODE_OFF);

  // clear is refused while the selected fault source is still asserted
  assign clear_req = i_we & hit(i_addr, `PFB_ADDR_STAT) &
                     i_wdata[`PFB_STAT_LATCH] & ~raw_fault;

  always_comb begin
    st_d = st_q;
    case (st_q)
      PFB_ST_RUN: begin
        if (fault_now) begin
          st_d = (mode == PFB_MODE_LATCHED) ? PFB_ST_HOLD : PFB_ST_TRIP;
        end
      end
      PFB_ST_TRIP: begin
        if (fault_now && mode == PFB_MODE_LATCHED) begin
          st_d = PFB_ST_HOLD;
        end else if (!fault_now) begin
          st_d = PFB_ST_RUN;
        end
      end
      PFB_ST_HOLD: begin
        // a new fault in the clear cycle keeps the latch set
        if (clear_req && !fault_now) begin
          st_d = PFB_ST_RUN;
        end
      end
      default: st_d = PFB_ST_HOLD;
    endcase
  end

  always_comb begin
    ph_d = i_pwm_high;
    pl_d = i_pwm_low;
    flt_d = (st_d != PFB_ST_RUN) | limit_in;
    oh_d = i_pwm_high;
    ol_d = i_pwm_low;
    if (flt_d) begin
      oh_d = fcl_q[`PFB_FCL_SAFEH];
      ol_d = fcl_q[`PFB_FCL_SAFEL];
    end
    // pin handed back only when the safety path is unused
    own_d = ~((mode == PFB_MODE_OFF) && (src != PFB_SRC_SAFETY));
  end

  assign stat = {10'h000, own_q, i_safety_fault_n, win | state_blk,
                 limit_in, flt_q, st_q == PFB_ST_HOLD};

  always_comb begin
    leb_d = leb_q;
    fcl_d = fcl_q;
    aux_d = aux_q;
    blk_d = blk_q;
    rdata_d = 16'h0000;
    if (i_we) begin
      if (hit(i_addr, `PFB_ADDR_LEB)) begin
        leb_d = i_wdata & `PFB_LEB_MASK;
      end
      if (hit(i_addr, `PFB_ADDR_FCL)) begin
        fcl_d = i_wdata & `PFB_FCL_MASK;
      end
      if (hit(i_addr, `PFB_ADDR_AUX)) begin
        aux_d = i_wdata & `PFB_AUX_MASK;
      end
      if (hit(i_addr, `PFB_ADDR_BLK)) begin
        blk_d = i_wdata[CW-1:0];
      end
    end
    if (i_re) begin
      case (i_addr)
        `PFB_ADDR_LEB: rdata_d = leb_q;
        `PFB_ADDR_FCL: rdata_d = fcl_q;
        `PFB_ADDR_AUX: rdata_d = aux_q;
        `PFB_ADDR_BLK: rdata_d = 16'(blk_q);
        `PFB_ADDR_STAT: rdata_d = stat;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      leb_q <= `PFB_LEB_RST;
      fcl_q <= `PFB_FCL_RST;
      aux_q <= `PFB_AUX_RST;
      blk_q <= CW'(`PFB_BLK_RST);
      rdata_q <= 16'h0000;
      st_q <= PFB_ST_RUN;
      ph_q <= 1'b0;
      pl_q <= 1'b0;
      oh_q <= 1'b0;
      ol_q <= 1'b0;
      flt_q <= 1'b0;
      own_q <= 1'b1;
    end else if (i_ce) begin
      leb_q <= leb_d;
      fcl_q <= fcl_d;
      aux_q <= aux_d;
      blk_q <= blk_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      ph_q <= ph_d;
      pl_q <= pl_d;
      oh_q <= oh_d;
      ol_q <= ol_d;
      flt_q <= flt_d;
      own_q <= own_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pwm_high = oh_q;
  assign o_pwm_low = ol_q;
  assign o_fault_active = flt_q;
  assign o_safety_pin_owned = own_q;
endmodule

// file: shared/pfb_map.svh
`ifndef PFB_MAP_SVH
`define PFB_MAP_SVH

// register word addresses
`define PFB_ADDR_LEB 4'h0
`define PFB_ADDR_FCL 4'h1
`define PFB_ADDR_AUX 4'h2
`define PFB_ADDR_BLK 4'h3
`define PFB_ADDR_STAT 4'h4

// leading_edge_blank_control fields
`define PFB_LEB_HRISE 15
`define PFB_LEB_HFALL 14
`define PFB_LEB_LRISE 13
`define PFB_LEB_LFALL 12
`define PFB_LEB_FLTEN 11
`define PFB_LEB_LIMEN 10
`define PFB_LEB_EXTH 5
`define PFB_LEB_EXTL 4
`define PFB_LEB_HH 3
`define PFB_LEB_HL 2
`define PFB_LEB_LH 1
`define PFB_LEB_LL 0
`define PFB_LEB_MASK 16'hfc3f
`define PFB_LEB_RST 16'h0000

// fault_limit_control_reg fields
`define PFB_FCL_MODE_LSB 0
`define PFB_FCL_SRC_LSB 2
`define PFB_FCL_LIMEN 4
`define PFB_FCL_SAFEH 5
`define PFB_FCL_SAFEL 6
`define PFB_FCL_MASK 16'h007f
`define PFB_FCL_RST 16'h0000

// auxiliary_control_reg fields
`define PFB_AUX_SEL_LSB 0
`define PFB_AUX_MASK 16'h000f
`define PFB_AUX_RST 16'h0000

// blanking length in clock cycles
`define PFB_BLK_RST 16'h0000

// status fields
`define PFB_STAT_LATCH 0
`define PFB_STAT_FAULT 1
`define PFB_STAT_LIMIT 2
`define PFB_STAT_BLANK 3
`define PFB_STAT_PIN 4
`define PFB_STAT_OWN 5

`endif

// file: shared/pfb_pkg.sv
package pfb_pkg;

  typedef enum logic [1:0] {
    PFB_MODE_LATCHED = 2'b00,
    PFB_MODE_CYCLE = 2'b01,
    PFB_MODE_RSVD = 2'b10,
    PFB_MODE_OFF = 2'b11
  } pfb_mode_t;

  typedef enum logic [1:0] {
    PFB_SRC_SAFETY = 2'b00,
    PFB_SRC_REMAP1 = 2'b01,
    PFB_SRC_REMAP2 = 2'b10,
    PFB_SRC_NONE = 2'b11
  } pfb_src_t;

  typedef enum logic [1:0] {
    PFB_ST_RUN = 2'b00,
    PFB_ST_TRIP = 2'b01,
    PFB_ST_HOLD = 2'b10
  } pfb_state_t;

endpackage
